/* include/host_port_cfg.svh */
// Constants for the host data-pin port: offsets, field positions,
// reset values and serial frame counts.
// Assumes inclusion by bare name from design and simulation files.
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// ------------------------------------------------------------
// Software register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_COUNT 4'h8

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CTRL_WEN_BIT 0
`define CTRL_RST 32'h0000_0001
`define ST_SERIAL_BIT 0
`define ST_CPOL_BIT 1
`define ST_CPHA_BIT 2
`define ST_SWAP_BIT 3
`define ST_SEL1_BIT 4
`define ST_SEL2_BIT 5
`define COUNT_RST 16'h0000
`define HREG_RST 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ------------------------------------------------------------
// Serial frame layout: rw, 14 address bits, B, 8 data bits
// ------------------------------------------------------------
`define FRM_RW_POS 5'h00
`define FRM_B_POS 5'h0f
`define FRM_DATA_POS 5'h10
`define FRM_LAST_POS 5'h17
`define FRM_BITS 5'h18

`endif

/* include/host_port_pkg.sv */
// Types shared by the host data-pin port modules.
// Assumes host_port_cfg.svh is on the include path.
package host_port_pkg;

  // Parallel host pins as one carrier
  typedef struct packed {
    logic sel1_n;
    logic sel2_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [7:0] data;
  } host_pins_t;

  // Static serial settings
  typedef struct packed {
    logic cpol;
    logic cpha;
    logic swap;
  } serial_cfg_t;

  // One decoded serial transfer
  typedef struct packed {
    logic rw;
    logic burst;
    logic [13:0] addr;
    logic [7:0] data;
  } serial_req_t;

  // Parallel bus phase
  typedef enum logic [1:0] {
    PAR_IDLE,
    PAR_READ,
    PAR_WRITE
  } par_phase_t;

endpackage

/* logic/sync2.sv */
// Two-flop synchroniser for a bundle of levels.
// Assumes each bit is a level that is stable for several clocks.
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First flop feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

/* logic/serial_frame.sv */
// Serial frame engine on the derived serial sample clock.
// Assumes settings stay static while a frame runs and that a frame
// is bounded by the channel selects (frame_idle high between frames).
`timescale 1ns/10ps
module serial_frame
  import host_port_pkg::*;
(
  input wire logic sample_clk,
  input wire logic frame_idle,
  input wire logic arst_n,
  input wire logic swap,
  input wire logic mosi,
  input wire logic [7:0] read_data,
  output host_port_pkg::serial_req_t req,
  output logic req_tgl,
  output logic miso,
  output logic miso_oe
);
  `include "host_port_cfg.svh"

  logic [4:0] cnt_reg;
  logic [2:0] idx;

  // Bit counter, cleared by the frame's own idle level
  always_ff @(posedge sample_clk or posedge frame_idle) begin
    if (frame_idle) begin
      cnt_reg <= 5'h00;
    end else if (cnt_reg != `FRM_BITS) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // Field capture; rw and B fixed, address and data follow swap
  always_ff @(posedge sample_clk or negedge arst_n) begin
    if (!arst_n) begin
      req <= '0;
    end else if (cnt_reg == `FRM_RW_POS) begin
      req.rw <= mosi;
    end else if (cnt_reg == `FRM_B_POS) begin
      req.burst <= mosi;
    end else if (cnt_reg < `FRM_B_POS) begin
      if (swap) begin
        req.addr <= {mosi, req.addr[13:1]};
      end else begin
        req.addr <= {req.addr[12:0], mosi};
      end
    end else if (cnt_reg <= `FRM_LAST_POS) begin
      if (swap) begin
        req.data <= {mosi, req.data[7:1]};
      end else begin
        req.data <= {req.data[6:0], mosi};
      end
    end
  end

  // Event toggle once the last write data bit is in
  always_ff @(posedge sample_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_tgl <= 1'b0;
    end else if (cnt_reg == `FRM_LAST_POS && !req.rw) begin
      req_tgl <= ~req_tgl;
    end
  end

  // Read bit index, one bit ahead: the top retimes the pin by one launch edge
  assign idx = 3'(cnt_reg - `FRM_B_POS);

  // Read data shifted out on the launch edge
  always_ff @(negedge sample_clk or posedge frame_idle) begin
    if (frame_idle) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else if (req.rw && cnt_reg >= `FRM_B_POS && cnt_reg < `FRM_LAST_POS) begin
      miso <= swap ? read_data[idx] : read_data[3'h7 - idx];
      miso_oe <= 1'b1;
    end else begin
      miso_oe <= 1'b0;
    end
  end

endmodule

/* logic/host_data_port.sv */
// Host register port: 8-bit parallel bus or serial interface, with a
// small register file for two channels and an AXI4-Lite status port.
// Assumes the host never asserts both channel selects at once and
// keeps the serial settings static during frames.
//
// What this block does
// - Parallel mode: data pins take write bits and return addressed register bits.
// - Data pins are undriven whenever both channel selects are high.
// - Serial mode takes clock polarity from its pin, default low.
// - Serial mode takes clock phase from its pin, default low.
// - Serial mode reverses address and data bit order when swap pin high.
// - Swap 0 shifts most significant bit first; swap 1 least significant first.
// - Read/write bit and B bit keep fixed control word positions.
// - Mode input 0 selects parallel bus, 1 selects serial interface.
// - Parallel write captures data at write strobe rising edge with a select low.
// - Parallel read drives register while read strobe and a select are low.
`timescale 1ns/10ps
module host_data_port
  import host_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host pins
  input wire logic bus_mode_serial,
  input wire logic channel_one_select_n,
  input wire logic channel_two_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic [7:0] host_data_oe,
  // Serial link
  input wire logic serial_clk,
  input wire logic serial_mosi,
  output logic serial_miso,
  output logic serial_miso_oe
);
  `include "host_port_cfg.svh"

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  host_pins_t pins_raw;
  host_pins_t pins_n;
  host_pins_t pins;
  logic mode_sync;
  logic mode_reg;
  logic wr_n_prev_reg;
  par_phase_t phase_reg;
  par_phase_t phase_next;
  logic [7:0] hreg_array [0:31];
  logic [4:0] par_index;
  logic par_write;
  logic sel_any;
  logic chan_two_reg;
  serial_cfg_t cfg_reg;
  logic sample_clk;
  logic frame_idle;
  serial_req_t ser_req;
  logic ser_tgl;
  logic ser_tgl_sync;
  logic ser_tgl_prev_reg;
  logic ser_write;
  logic [4:0] ser_index;
  logic [7:0] ser_read_data;
  logic miso_int;
  logic miso_oe_int;
  logic [31:0] ctrl_reg;
  logic [15:0] count_reg;
  logic [31:0] status_word;
  logic aw_done_reg;
  logic w_done_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Gather the parallel pins into one carrier
  assign pins_raw.sel1_n = channel_one_select_n;
  assign pins_raw.sel2_n = channel_two_select_n;
  assign pins_raw.rd_n = read_strobe_n;
  assign pins_raw.wr_n = write_strobe_n;
  assign pins_raw.addr = host_addr;
  assign pins_raw.data = host_data_in;

  // Host pins pass two flops before use (frame_idle takes the raw selects); carried inverted so that the
  // chain's reset value is the idle high level, with no false select
  sync2 #(
    .W($bits(host_pins_t))
  ) u_pin_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d(~pins_raw),
    .q(pins_n)
  );
  assign pins = host_pins_t'(~pins_n);

  // Mode select pin
  sync2 #(
    .W(1)
  ) u_mode_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d(bus_mode_serial),
    .q(mode_sync)
  );

  // Serial write event toggle from the link side
  sync2 #(
    .W(1)
  ) u_tgl_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d(ser_tgl),
    .q(ser_tgl_sync)
  );

  // ------------------------------------------------------------
  // Mode and serial settings
  // ------------------------------------------------------------
  assign sel_any = ~pins.sel1_n | ~pins.sel2_n;

  // Bus mode follows its select input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= 1'b0;
    end else begin
      mode_reg <= mode_sync;
    end
  end

  // Settings sampled from the upper data pins only between frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= '0;
    end else if (mode_reg && !sel_any) begin
      cfg_reg.cpol <= pins.data[7];
      cfg_reg.cpha <= pins.data[6];
      cfg_reg.swap <= pins.data[5];
    end
  end

  // Channel held from whichever select is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_two_reg <= 1'b0;
    end else if (!pins.sel1_n) begin
      chan_two_reg <= 1'b0;
    end else if (!pins.sel2_n) begin
      chan_two_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Parallel bus
  // ------------------------------------------------------------
  // Previous write strobe level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_n_prev_reg <= 1'b1;
    end else begin
      wr_n_prev_reg <= pins.wr_n;
    end
  end

  assign par_index = {~pins.sel2_n, pins.addr};
  assign par_write = !mode_reg && sel_any && !wr_n_prev_reg && pins.wr_n;

  // Bus phase from strobes and selects
  always_comb begin
    phase_next = PAR_IDLE;
    if (!mode_reg && sel_any) begin
      if (!pins.rd_n) begin
        phase_next = PAR_READ;
      end else if (!pins.wr_n) begin
        phase_next = PAR_WRITE;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= PAR_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Data pins: drive the addressed register only in a read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_data_out <= 8'h00;
      host_data_oe <= 8'h00;
    end else begin
      case (phase_next)
        PAR_READ: begin
          host_data_out <= hreg_array[par_index];
          host_data_oe <= 8'hff;
        end
        PAR_WRITE: begin
          host_data_oe <= 8'h00;
        end
        default: begin
          host_data_oe <= 8'h00;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Serial link domain
  // ------------------------------------------------------------
  // Sample edge is the rising edge of this derived clock
  assign sample_clk = serial_clk ^ cfg_reg.cpol ^ cfg_reg.cpha;
  assign frame_idle = ~mode_reg | (channel_one_select_n & channel_two_select_n);
  assign ser_index = {chan_two_reg, ser_req.addr[3:0]};
  // Register file is quiet in serial mode while a read frame runs
  assign ser_read_data = hreg_array[ser_index];

  serial_frame u_frame (
    .sample_clk(sample_clk),
    .frame_idle(frame_idle),
    .arst_n(aresetn),
    .swap(cfg_reg.swap),
    .mosi(serial_mosi),
    .read_data(ser_read_data),
    .req(ser_req),
    .req_tgl(ser_tgl),
    .miso(miso_int),
    .miso_oe(miso_oe_int)
  );

  // Link outputs retimed by their own flops on the launch edge
  always_ff @(negedge sample_clk or posedge frame_idle) begin
    if (frame_idle) begin
      serial_miso <= 1'b0;
      serial_miso_oe <= 1'b0;
    end else begin
      serial_miso <= miso_int;
      serial_miso_oe <= miso_oe_int;
    end
  end

  // Serial write event edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_tgl_prev_reg <= 1'b0;
    end else begin
      ser_tgl_prev_reg <= ser_tgl_sync;
    end
  end

  assign ser_write = mode_reg && (ser_tgl_sync != ser_tgl_prev_reg);

  // ------------------------------------------------------------
  // Host register file
  // ------------------------------------------------------------
  // Writes from either mode, gated by the software write enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 32; i++) begin
        hreg_array[i] <= `HREG_RST;
      end
    end else if (ctrl_reg[`CTRL_WEN_BIT]) begin
      if (par_write) begin
        hreg_array[par_index] <= pins.data;
      end else if (ser_write) begin
        hreg_array[ser_index] <= ser_req.data;
      end
    end
  end

  // Count of accepted host writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= `COUNT_RST;
    end else if (ctrl_reg[`CTRL_WEN_BIT] && (par_write || ser_write)) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  // Live status word
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_SERIAL_BIT] = mode_reg;
    status_word[`ST_CPOL_BIT] = cfg_reg.cpol;
    status_word[`ST_CPHA_BIT] = cfg_reg.cpha;
    status_word[`ST_SWAP_BIT] = cfg_reg.swap;
    status_word[`ST_SEL1_BIT] = ~pins.sel1_n;
    status_word[`ST_SEL2_BIT] = ~pins.sel2_n;
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_done_reg <= 1'b0;
      awaddr_reg <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_done_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_done_reg <= 1'b0;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_done_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_done_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_done_reg <= 1'b0;
    end
  end

  // Ready flags drop on capture and rise after the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_done_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_done_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Register write and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (aw_done_reg && w_done_reg && !s_axi_bvalid) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_reg == `OFS_CTRL) begin
        s_axi_bresp <= `RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            ctrl_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
          end
        end
      end else if (awaddr_reg == `OFS_STATUS || awaddr_reg == `OFS_COUNT) begin
        s_axi_bresp <= `RESP_OKAY;
      end else begin
        s_axi_bresp <= `RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        `OFS_CTRL: s_axi_rdata <= ctrl_reg;
        `OFS_STATUS: s_axi_rdata <= status_word;
        `OFS_COUNT: s_axi_rdata <= {16'h0000, count_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* sim/host_data_port_asserts.sv */
// Checker for the host data-pin port: pin release and AXI answers.
// Assumes it is bound to host_data_port and sees its ports only.
`timescale 1ns/10ps
`include "host_port_cfg.svh"
module host_data_port_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_mode_serial,
  input wire logic channel_one_select_n,
  input wire logic channel_two_select_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] host_data_oe,
  input wire logic serial_miso_oe,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid
);
  // ----
  // Checks
  // ----
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_BUS_FLOAT: assert property (
    (channel_one_select_n && channel_two_select_n) [*5] |-> host_data_oe == 8'h00)
    else $error("data pins driven while both selects idle");
  AST_MISO_FLOAT: assert property (
    (channel_one_select_n && channel_two_select_n) [*2] |-> !serial_miso_oe)
    else $error("serial out driven while both selects idle");
  AST_READ_DRIVE: assert property (
    (!read_strobe_n && (channel_one_select_n != channel_two_select_n) && !bus_mode_serial) [*5]
    |-> host_data_oe == 8'hff)
    else $error("data pins not driven during a read");
  AST_READ_STOP: assert property (
    read_strobe_n [*5] |-> host_data_oe == 8'h00)
    else $error("data pins driven without a read");
  AST_SERIAL_QUIET: assert property (
    bus_mode_serial [*5] |-> host_data_oe == 8'h00)
    else $error("parallel drive in serial mode");
  AST_R_NEXT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_UNMAPPED: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hc
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_B_SOON: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
endmodule

bind host_data_port host_data_port_checker checker_i (.*);

/* sim/host_model.sv */
// Host processor model: parallel strobe cycles and serial frames.
// Assumes the bench resolves the shared data pins into host_data_in.
`timescale 1ns/10ps
module host_model (
  input wire logic aclk,
  input wire logic [7:0] host_data_in,
  input wire logic miso_line,
  output logic bus_mode_serial,
  output logic channel_one_select_n,
  output logic channel_two_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] host_addr,
  output logic [7:0] pin_drive,
  output logic pin_drive_en,
  output logic serial_clk,
  output logic serial_mosi
);
  // ----
  // Pin cycles
  // ----
  initial begin
    bus_mode_serial = 1'b0;
    channel_one_select_n = 1'b1;
    channel_two_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_addr = 4'h0;
    pin_drive = 8'h00;
    pin_drive_en = 1'b0;
    serial_clk = 1'b0;
    serial_mosi = 1'b0;
  end
  // Select exactly one channel
  task automatic pick(input logic ch, input logic [3:0] a);
    @(posedge aclk);
    channel_one_select_n <= ch;
    channel_two_select_n <= !ch;
    host_addr <= a;
  endtask
  // Deselect and let the bus float
  task automatic drop();
    @(posedge aclk);
    channel_one_select_n <= 1'b1;
    channel_two_select_n <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask
  // Write: data held three clocks before the strobe fall and after its rise
  task automatic par_wr(input logic ch, input logic [3:0] a, input logic [7:0] d);
    pick(ch, a);
    pin_drive <= d;
    pin_drive_en <= 1'b1;
    repeat (3) @(posedge aclk);
    write_strobe_n <= 1'b0;
    repeat (3) @(posedge aclk);
    write_strobe_n <= 1'b1;
    repeat (3) @(posedge aclk);
    pin_drive_en <= 1'b0;
    drop();
  endtask
  // Read: sample the pins once the device drives them
  task automatic par_rd(input logic ch, input logic [3:0] a, output logic [7:0] d);
    pick(ch, a);
    read_strobe_n <= 1'b0;
    repeat (5) @(posedge aclk);
    d = host_data_in;
    read_strobe_n <= 1'b1;
    drop();
  endtask
  // Mode and static serial settings on pins 7..5, selects idle
  task automatic set_mode(input logic s, input logic [2:0] c);
    @(posedge aclk);
    bus_mode_serial <= s;
    pin_drive <= {c, 5'h00};
    pin_drive_en <= s;
    serial_clk <= c[2];
    repeat (8) @(posedge aclk);
  endtask
  // One 24-bit frame, first bit is f[23]; clock stands still outside
  task automatic spi(input logic ch, input logic [23:0] f, output logic [7:0] r);
    pick(ch, 4'h0);
    #37;
    for (int i = 23; i >= 0; i--) begin
      if (!pin_drive[6]) serial_mosi = f[i];
      #80 serial_clk = !pin_drive[7];
      if (pin_drive[6]) serial_mosi = f[i];
      else r = {r[6:0], miso_line};
      #80 serial_clk = pin_drive[7];
      if (pin_drive[6]) r = {r[6:0], miso_line};
    end
    #80 serial_mosi = !serial_mosi;
    drop();
  endtask
endmodule

/* sim/testbench.sv */
// Testbench for the host data-pin port: AXI status, parallel cycles,
// serial frames in four clock modes. Assumes host_model on the pins.
`timescale 1ns/10ps
`include "host_port_cfg.svh"
module testbench;
  import host_port_pkg::*;
  logic aclk, aresetn, bus_mode_serial, read_strobe_n, write_strobe_n;
  logic channel_one_select_n, channel_two_select_n, pin_drive_en;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic serial_clk, serial_mosi, serial_miso, serial_miso_oe, miso_line;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, host_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] host_data_in, host_data_out, host_data_oe, pin_drive;
  int n_mismatch;
  int checks;
  // ----
  // Wiring
  // ----
  host_data_port dut (.*);
  host_model host (.*);
  // Shared pins: device drive wins, a released pin shows the inverse
  assign host_data_in = (host_data_oe & host_data_out) | (~host_data_oe & (pin_drive_en ? pin_drive : ~pin_drive));
  assign miso_line = serial_miso_oe ? serial_miso : !pin_drive[0];
  initial begin
    aclk = 1'b0;
    forever #20 aclk = !aclk;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Frame bits: rw, address, B, data; swap reverses address and data
  function automatic logic [23:0] mk(input logic rw, input logic [13:0] a, input logic [7:0] d, input logic s);
    logic [13:0] ra;
    logic [7:0] rd;
    for (int j = 0; j < 14; j++) ra[j] = a[13 - j];
    for (int j = 0; j < 8; j++) rd[j] = d[7 - j];
    return {rw, s ? ra : a, 1'b0, s ? rd : d};
  endfunction
  task automatic t_reset();
    rd_chk(`OFS_CTRL, 32'h0000_0001, `RESP_OKAY);
    rd_chk(`OFS_STATUS, 32'h0, `RESP_OKAY);
    rd_chk(`OFS_COUNT, 32'h0, `RESP_OKAY);
    rd_chk(4'hc, 32'h0, `RESP_SLVERR);
  endtask
  task automatic t_par();
    logic [1:0] r;
    logic [7:0] q;
    host.par_wr(1'b0, 4'h3, 8'ha5);
    host.par_wr(1'b1, 4'h3, 8'h5a);
    host.par_rd(1'b0, 4'h3, q);
    chk({24'h0, q}, 32'h0000_00a5);
    host.par_rd(1'b1, 4'h3, q);
    chk({24'h0, q}, 32'h0000_005a);
    chk({24'h0, host_data_oe}, 32'h0);
    axi_wr(`OFS_CTRL, 32'h0, r);
    host.par_wr(1'b0, 4'h3, 8'hff);
    host.par_rd(1'b0, 4'h3, q);
    chk({24'h0, q}, 32'h0000_00a5);
    axi_wr(`OFS_CTRL, 32'h0000_0001, r);
    rd_chk(`OFS_COUNT, 32'h0000_0002, `RESP_OKAY);
    axi_wr(4'hc, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    axi_wr(`OFS_STATUS, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    rd_chk(`OFS_STATUS, 32'h0, `RESP_OKAY);
  endtask
  task automatic t_serial();
    logic [2:0] cf [4] = '{3'h0, 3'h3, 3'h5, 3'h6};
    logic [23:0] f;
    logic [7:0] q;
    for (int k = 0; k < 4; k++) begin
      host.set_mode(1'b1, cf[k]);
      rd_chk(`OFS_STATUS, {28'h0, cf[k][0], cf[k][1], cf[k][2], 1'b1}, `RESP_OKAY);
      f = mk(1'b0, 14'(k + 4), 8'(8'hc1 + k), cf[k][0]);
      host.spi(1'b0, f, q);
      host.spi(1'b0, {1'b1, f[22:0]}, q);
      chk({24'h0, q}, {24'h0, f[7:0]});
    end
    host.set_mode(1'b0, 3'h0);
    rd_chk(`OFS_COUNT, 32'h0000_0006, `RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      host.par_rd(1'b0, 4'(k + 4), q);
      chk({24'h0, q}, {24'h0, 8'(8'hc1 + k)});
    end
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    n_mismatch = 0;
    checks = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_par();
    t_serial();
    stop_test();
  end
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
endmodule
